// >>> pkg/iceep_pkg.sv
// shared constants and types for the configuration eeprom programmer
`default_nettype none
package iceep_pkg;
	// configuration register indices
	localparam logic [7:0] IDX_STATUS = 8'h05;
	localparam logic [7:0] IDX_CTRL = 8'hf0;
	localparam logic [7:0] IDX_ADDR = 8'hf1;
	localparam logic [7:0] IDX_DHI = 8'hf2;
	localparam logic [7:0] IDX_DLO = 8'hf3;
	// control register fields
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_OP_MSB = 1;
	localparam int CTRL_GO_BIT = 2;
	localparam int CTRL_TOP_BIT = 7;
	localparam int STATUS_DONE_BIT = 0;
	localparam logic [1:0] OP_READ = 2'b10;
	localparam logic [1:0] OP_WRITE = 2'b01;
	// reset values and the erased-word read value
	localparam logic [1:0] OP_RST = 2'b00;
	localparam logic [7:0] ADDR_RST = 8'h00;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [7:0] RDATA_RST = 8'h00;
	localparam logic [15:0] BLANK_WORD = 16'hffff;
	// array geometry: 6 kbit of 16-bit words, lower 4 kbit for card logic
	localparam int ARRAY_WORDS = 384;
	localparam int GEN_WORDS = 256;
	// timing
	localparam int CLK_HZ = 25000000;
	localparam int T_PROG_MS = 10;
	localparam int PROG_CYCLES = T_PROG_MS * (CLK_HZ / 1000);
	// serial framing: 2 opcode bits + 8 address bits, then 16 data bits
	localparam int SER_HDR_BITS = 10;
	localparam int SER_DATA_BITS = 16;
	typedef struct packed {
		logic we;
		logic [8:0] addr;
		logic [15:0] wdata;
	} iceep_req_t;
endpackage
`default_nettype wire

// >>> design/iceep_serial.sv
// four-wire serial eeprom port for on-card logic
`timescale 1ns/1ps
`default_nettype none
module iceep_serial import iceep_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cs_pin,
	input wire logic sk_pin,
	input wire logic di_pin,
	input wire logic ack,
	input wire logic busy,
	input wire logic [15:0] rdata,
	output logic req_valid,
	output iceep_req_t req,
	output logic do_ff
);
	typedef enum logic [2:0] {S_IDLE, S_HDR, S_RWAIT, S_RD, S_WDATA, S_WREQ, S_DONE} iceep_ss_t;
	iceep_ss_t st_ff, nxt_st;
	// {cs, sk, di}; a change counts once stages two and three agree
	logic [2:0] s1_ff, s2_ff, s3_ff, flt_ff;
	logic sk_prev_ff;
	logic [4:0] cnt_ff, nxt_cnt;
	logic [9:0] hdr_ff, nxt_hdr;
	logic [15:0] sh_ff, nxt_sh;
	logic nxt_do;
	wire [2:0] agree = ~(s2_ff ^ s3_ff);
	wire [2:0] nxt_flt = (agree & s2_ff) | (~agree & flt_ff);
	wire cs = flt_ff[2];
	wire di = flt_ff[0];
	wire rise = flt_ff[1] & ~sk_prev_ff;
	wire [1:0] op = hdr_ff[9:8];

	assign req_valid = (st_ff == S_RWAIT) || (st_ff == S_WREQ);
	assign req.we = (st_ff == S_WREQ);
	assign req.addr = {1'b0, hdr_ff[7:0]};
	assign req.wdata = sh_ff;

	always_comb begin
		nxt_st = st_ff;
		nxt_cnt = cnt_ff;
		nxt_hdr = hdr_ff;
		nxt_sh = sh_ff;
		nxt_do = cs & ~busy;
		if (!cs) begin
			nxt_st = S_IDLE;
			nxt_cnt = 5'h00;
			nxt_do = 1'b0;
		end else begin
			unique case (st_ff)
				S_IDLE: begin
					if (rise && di) begin
						nxt_st = S_HDR;
						nxt_cnt = 5'h00;
					end
				end
				S_HDR: begin
					if (rise) begin
						nxt_hdr = {hdr_ff[8:0], di};
						nxt_cnt = cnt_ff + 5'h01;
						if (cnt_ff == 5'(SER_HDR_BITS - 1)) begin
							nxt_cnt = 5'h00;
							if (nxt_hdr[9:8] == OP_READ) nxt_st = S_RWAIT;
							else if (nxt_hdr[9:8] == OP_WRITE) nxt_st = S_WDATA;
							else nxt_st = S_DONE;
						end
					end
				end
				S_RWAIT: begin
					// a clock edge before the word arrives means the array was busy
					if (ack) begin
						nxt_st = S_RD;
						nxt_sh = rdata;
						nxt_do = 1'b0;
					end else if (rise) begin
						nxt_st = S_DONE;
					end else begin
						nxt_do = do_ff;
					end
				end
				S_RD: begin
					nxt_do = do_ff;
					if (rise) begin
						nxt_do = sh_ff[15];
						nxt_sh = {sh_ff[14:0], 1'b0};
						nxt_cnt = cnt_ff + 5'h01;
						if (cnt_ff == 5'(SER_DATA_BITS - 1)) nxt_st = S_DONE;
					end
				end
				S_WDATA: begin
					if (rise) begin
						nxt_sh = {sh_ff[14:0], di};
						nxt_cnt = cnt_ff + 5'h01;
						if (cnt_ff == 5'(SER_DATA_BITS - 1)) nxt_st = S_WREQ;
					end
				end
				S_WREQ: begin
					// busy until granted, so no ready level precedes the programming
					nxt_do = 1'b0;
					if (ack) nxt_st = S_DONE;
				end
				S_DONE: begin
					nxt_st = S_DONE;
				end
				default: nxt_st = S_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_ff <= 3'h0;
			s2_ff <= 3'h0;
			s3_ff <= 3'h0;
			flt_ff <= 3'h0;
			sk_prev_ff <= 1'b0;
		end else begin
			s1_ff <= {cs_pin, sk_pin, di_pin};
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			flt_ff <= nxt_flt;
			sk_prev_ff <= flt_ff[1];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= S_IDLE;
			cnt_ff <= 5'h00;
			hdr_ff <= 10'h000;
			sh_ff <= 16'h0000;
			do_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			cnt_ff <= nxt_cnt;
			hdr_ff <= nxt_hdr;
			sh_ff <= nxt_sh;
			do_ff <= nxt_do;
		end
	end
endmodule // iceep_serial
`default_nettype wire

// >>> design/iceep_top.sv
// configuration eeprom programmer: host registers, arbiter and array
`timescale 1ns/1ps
`default_nettype none
module iceep_top import iceep_pkg::*; #(
	parameter int WORDS = ARRAY_WORDS,
	parameter int PROG_CNT = PROG_CYCLES
) (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic CFG_STATE,
	input wire logic [7:0] REG_INDEX,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	input wire logic SERIAL_PORT_SELECT,
	input wire logic SERIAL_PORT_CLOCK,
	input wire logic SERIAL_PORT_INPUT,
	output logic SERIAL_PORT_OUTPUT
);
	localparam int CW = $clog2(PROG_CNT + 1);
	localparam int AW = $clog2(WORDS);

	if (PROG_CNT < 1) begin : g_bad_prog
		$error("iceep_top: PROG_CNT must be at least 1");
	end
	// nine host address bits; the serial port needs the lower GEN_WORDS words
	if (WORDS < GEN_WORDS || WORDS > 512) begin : g_bad_words
		$error("iceep_top: WORDS must lie in 256..512");
	end

	typedef enum logic [1:0] {A_IDLE, A_RDAT, A_PROG, A_FIN} iceep_arb_t;
	iceep_arb_t arb_ff, nxt_arb;

	// the lower GEN_WORDS words are shared with the serial port
	logic [15:0] mem [0:WORDS-1];
	logic [15:0] rd_q_ff;
	logic [CW-1:0] cnt_ff, nxt_cnt;
	logic owner_ser_ff;
	logic [1:0] op_ff;
	logic go_ff, top_ff;
	logic [7:0] addr_ff, dhi_ff, dlo_ff, rdata_ff;
	logic nxt_go;
	// request and data out of the serial port
	logic sp_valid;
	iceep_req_t sp_req;
	logic sp_do;

	// one index decode serves both the write strobes and the read selection
	wire hit_stat = (REG_INDEX == IDX_STATUS);
	wire hit_ctrl = (REG_INDEX == IDX_CTRL);
	wire hit_addr = (REG_INDEX == IDX_ADDR);
	wire hit_dhi = (REG_INDEX == IDX_DHI);
	wire hit_dlo = (REG_INDEX == IDX_DLO);

	// host register writes, gated by configuration state
	wire wr_ok = REG_WR & CFG_STATE;
	wire wr_ctrl = wr_ok & hit_ctrl;
	wire wr_addr = wr_ok & hit_addr;
	wire wr_dhi = wr_ok & hit_dhi;
	wire wr_dlo = wr_ok & hit_dlo;

	// grant: host has priority, the serial side waits while busy
	wire idle = (arb_ff == A_IDLE);
	wire isa_go = go_ff & idle;
	wire isa_rd = isa_go & (op_ff == OP_READ);
	wire isa_wr = isa_go & (op_ff == OP_WRITE);
	wire isa_nop = isa_go & ~isa_rd & ~isa_wr;
	wire ser_go = sp_valid & idle & ~go_ff;
	wire g_start = (isa_rd | isa_wr) | ser_go;
	wire g_we = isa_go ? isa_wr : sp_req.we;
	wire [8:0] isa_addr = {top_ff, addr_ff};
	wire [8:0] g_addr = isa_go ? isa_addr : sp_req.addr;
	wire [15:0] g_wdata = isa_go ? {dhi_ff, dlo_ff} : sp_req.wdata;
	// words above the array are never written and read back as erased
	wire in_range = ({23'h000000, g_addr} < WORDS);
	wire [AW-1:0] g_idx = g_addr[AW-1:0];
	// a pending host go already counts as busy, so the serial side holds off
	wire busy = go_ff | ~idle;

	// completion and hand-off of the latched word
	wire fin_isa = (arb_ff == A_FIN) & ~owner_ser_ff;
	wire load_rd = (arb_ff == A_RDAT) & ~owner_ser_ff;
	// serial writes are acknowledged at the grant, serial reads once the word is latched
	wire ser_ack = (ser_go & sp_req.we) | ((arb_ff == A_RDAT) & owner_ser_ff);
	wire prog_end = (cnt_ff == CW'(PROG_CNT - 1));

	// register read selection; reserved control bits read as zero
	wire [7:0] ctrl_rd = {top_ff, 4'h0, go_ff, op_ff};
	// 0 while a go is pending or running, 1 once done
	wire [7:0] stat_rd = {7'h00, ~go_ff};
	wire [7:0] rd_mux =
		hit_stat ? stat_rd :
		hit_ctrl ? ctrl_rd :
		hit_addr ? addr_ff :
		hit_dhi ? dhi_ff :
		hit_dlo ? dlo_ff : 8'h00;
	// outside configuration state every read returns zero
	wire [7:0] nxt_rdata = CFG_STATE ? rd_mux : 8'h00;

	assign REG_RDATA = rdata_ff;
	assign SERIAL_PORT_OUTPUT = sp_do;

	// a host go arriving as the previous operation finishes is kept
	always_comb begin
		nxt_go = go_ff;
		if (fin_isa) nxt_go = 1'b0;
		if (wr_ctrl && REG_WDATA[CTRL_GO_BIT]) nxt_go = 1'b1;
	end

	always_comb begin
		nxt_arb = arb_ff;
		nxt_cnt = cnt_ff;
		unique case (arb_ff)
			A_IDLE: begin
				nxt_cnt = '0;
				if (isa_nop) nxt_arb = A_FIN;
				else if (g_start) nxt_arb = g_we ? A_PROG : A_RDAT;
			end
			// the word sits in the read latch for one cycle
			A_RDAT: nxt_arb = A_FIN;
			A_PROG: begin
				// busy held for the full programming time
				nxt_cnt = cnt_ff + CW'(1);
				if (prog_end) nxt_arb = A_FIN;
			end
			// one cycle for the host go to clear before the next grant
			A_FIN: nxt_arb = A_IDLE;
		endcase
	end

	// array has no reset: contents are nonvolatile
	always_ff @(posedge CLK) begin
		if (g_start && g_we && in_range) begin
			mem[g_idx] <= g_wdata;
		end
		if (g_start && !g_we) begin
			rd_q_ff <= in_range ? mem[g_idx] : BLANK_WORD;
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			arb_ff <= A_IDLE;
			cnt_ff <= '0;
			owner_ser_ff <= 1'b0;
			go_ff <= 1'b0;
		end else begin
			arb_ff <= nxt_arb;
			cnt_ff <= nxt_cnt;
			go_ff <= nxt_go;
			if (g_start) owner_ser_ff <= ~isa_go;
		end
	end

	// host-written fields; the go bit sits with the arbiter above
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			op_ff <= OP_RST;
			top_ff <= 1'b0;
			addr_ff <= ADDR_RST;
		end else begin
			if (wr_ctrl) begin
				op_ff <= REG_WDATA[CTRL_OP_MSB:CTRL_OP_LSB];
				top_ff <= REG_WDATA[CTRL_TOP_BIT];
			end
			if (wr_addr) addr_ff <= REG_WDATA;
		end
	end

	// a completed read overrides a host write landing in the same cycle
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			dhi_ff <= DATA_RST;
			dlo_ff <= DATA_RST;
		end else if (load_rd) begin
			dhi_ff <= rd_q_ff[15:8];
			dlo_ff <= rd_q_ff[7:0];
		end else begin
			if (wr_dhi) dhi_ff <= REG_WDATA;
			if (wr_dlo) dlo_ff <= REG_WDATA;
		end
	end

	// read data stays in a flop until the next read strobe
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			rdata_ff <= RDATA_RST;
		end else if (REG_RD) begin
			rdata_ff <= nxt_rdata;
		end
	end

	iceep_serial u_serial (
		.clk(CLK),
		.rst_n(RSTN),
		.cs_pin(SERIAL_PORT_SELECT),
		.sk_pin(SERIAL_PORT_CLOCK),
		.di_pin(SERIAL_PORT_INPUT),
		.ack(ser_ack),
		.busy(busy),
		.rdata(rd_q_ff),
		.req_valid(sp_valid),
		.req(sp_req),
		.do_ff(sp_do)
	);
endmodule // iceep_top
`default_nettype wire

// >>> verif/iceep_monitor.sv
// port checker for the configuration eeprom programmer
`timescale 1ns/1ps
`default_nettype none
module iceep_monitor import iceep_pkg::*; #(
	parameter int PROG_CNT = 20
) (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic CFG_STATE,
	input wire logic [7:0] REG_INDEX,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_RDATA,
	input wire logic SERIAL_PORT_SELECT,
	input wire logic SERIAL_PORT_OUTPUT
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);
	wire logic rd_ok;
	wire logic wr_ok;
	wire logic mapped;
	wire logic top_in;
	logic [31:0] cnt_ff;
	logic [31:0] nxt_cnt;
	assign rd_ok = REG_RD && CFG_STATE;
	assign wr_ok = REG_WR && CFG_STATE;
	assign mapped = REG_INDEX inside {IDX_STATUS, IDX_CTRL, IDX_ADDR, IDX_DHI, IDX_DLO};
	assign top_in = REG_WDATA[7];
	// only a lower bound of the write window, so later serial traffic cannot trip it
	assign nxt_cnt = (wr_ok && REG_INDEX == IDX_CTRL && REG_WDATA[2:0] == 3'h5) ? 32'(PROG_CNT)
		: (cnt_ff != 32'h0 ? cnt_ff - 32'h1 : 32'h0);
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) cnt_ff <= 32'h0;
		else cnt_ff <= nxt_cnt;
	end
	a_closed_read: assert property (REG_RD && !CFG_STATE |=> REG_RDATA == 8'h00)
		else $error("read outside configuration state not zero");
	a_unmapped_read: assert property (rd_ok && !mapped |=> REG_RDATA == 8'h00)
		else $error("unmapped index read not zero");
	a_reserved_zero: assert property (rd_ok && REG_INDEX == IDX_CTRL |=> REG_RDATA[6:3] == 4'h0)
		else $error("reserved control bits not zero");
	a_addr_back: assert property (wr_ok && REG_INDEX == IDX_ADDR
		##1 rd_ok && REG_INDEX == IDX_ADDR |=> REG_RDATA == $past(REG_WDATA, 2))
		else $error("address low byte not kept");
	a_top_bit: assert property (wr_ok && REG_INDEX == IDX_CTRL
		##1 rd_ok && REG_INDEX == IDX_CTRL |=> REG_RDATA[7] == $past(top_in, 2))
		else $error("address top bit not kept");
	a_write_busy: assert property (rd_ok && REG_INDEX == IDX_STATUS && cnt_ff != 32'h0
		|=> !REG_RDATA[STATUS_DONE_BIT])
		else $error("done shown inside programming time");
	a_go_held: assert property (rd_ok && REG_INDEX == IDX_CTRL && cnt_ff != 32'h0
		|=> REG_RDATA[CTRL_GO_BIT])
		else $error("go bit dropped while programming");
	a_quiet_out: assert property ((!SERIAL_PORT_SELECT) [*6] |-> !SERIAL_PORT_OUTPUT)
		else $error("serial output high while deselected");
endmodule // iceep_monitor
bind iceep_top iceep_monitor #(.PROG_CNT(PROG_CNT)) u_mon (.CLK(CLK), .RSTN(RSTN),
	.CFG_STATE(CFG_STATE), .REG_INDEX(REG_INDEX), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
	.REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .SERIAL_PORT_SELECT(SERIAL_PORT_SELECT),
	.SERIAL_PORT_OUTPUT(SERIAL_PORT_OUTPUT));
`default_nettype wire

// >>> verif/iceep_card.sv
// on-card client of the four-wire serial eeprom port
`timescale 1ns/1ps
`default_nettype none
module iceep_card (
	input wire logic clk,
	output logic cs,
	output logic sk,
	output logic di,
	input wire logic dout
);
	initial begin
		cs = 1'b0;
		sk = 1'b0;
		di = 1'b0;
	end
	// slow edges: the pins pass a synchroniser inside the device
	task automatic pulse(input logic b);
		@(posedge clk) di <= b;
		repeat (2) @(posedge clk);
		sk <= 1'b1;
		repeat (5) @(posedge clk);
		sk <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	task automatic xfer(input logic [1:0] op, input logic [7:0] a, input logic [15:0] w,
		output logic [16:0] r);
		int i;
		@(posedge clk) cs <= 1'b1;
		pulse(1'b1);
		for (i = 1; i >= 0; i--) pulse(op[i]);
		for (i = 7; i >= 0; i--) pulse(a[i]);
		@(negedge clk) r[16] = dout;
		if (op == 2'b10) begin
			for (i = 15; i >= 0; i--) begin
				pulse(~di);
				@(negedge clk) r[i] = dout;
			end
		end else begin
			for (i = 15; i >= 0; i--) pulse(w[i]);
			repeat (8) @(posedge clk);
			for (i = 0; i < 2000 && dout !== 1'b1; i++) @(posedge clk);
			r[0] = dout;
		end
		@(posedge clk) cs <= 1'b0;
		di <= ~di;
		repeat (10) @(posedge clk);
	endtask
endmodule // iceep_card
`default_nettype wire

// >>> verif/isa_config_eeprom_programmer_tb.sv
// self-checking bench for the configuration eeprom programmer
`timescale 1ns/1ps
`default_nettype none
module isa_config_eeprom_programmer_tb import iceep_pkg::*; ();
	localparam int P = 20;
	localparam int W = 384;
	logic clk;
	logic rstn;
	logic cfg;
	logic [7:0] idx;
	logic [7:0] wdat;
	logic wr;
	logic rd;
	logic [7:0] rdat;
	logic cs;
	logic sk;
	logic di;
	logic dout;
	logic [15:0] mem [0:511];
	logic [16:0] sr;
	logic [8:0] ad;
	logic [7:0] v;
	logic [15:0] rw;
	int n_errors;
	int n_checks;
	int seed;
	int cyc;
	int j;
	iceep_top #(.WORDS(W), .PROG_CNT(P)) DUT (.CLK(clk), .RSTN(rstn), .CFG_STATE(cfg),
		.REG_INDEX(idx), .REG_WDATA(wdat), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdat),
		.SERIAL_PORT_SELECT(cs), .SERIAL_PORT_CLOCK(sk), .SERIAL_PORT_INPUT(di),
		.SERIAL_PORT_OUTPUT(dout));
	iceep_card card (.clk(clk), .cs(cs), .sk(sk), .di(di), .dout(dout));
	task automatic results();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		n_checks++;
		if (s !== e) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wreg(input logic [7:0] i, input logic [7:0] d);
		wr <= 1'b1;
		rd <= 1'b0;
		idx <= i;
		wdat <= d;
		@(posedge clk);
	endtask
	task automatic rreg(input logic [7:0] i, output logic [7:0] d);
		rd <= 1'b1;
		wr <= 1'b0;
		idx <= i;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdat;
		@(posedge clk);
	endtask
	function automatic logic [15:0] ex(input logic [8:0] a);
		return a >= 9'(W) ? 16'hffff : mem[a];
	endfunction
	// a write opcode is parked without go first, so a premature start corrupts the word
	task automatic hop(input logic [8:0] a, input logic [1:0] op, input logic [15:0] d);
		int k;
		logic [7:0] s;
		wreg(IDX_ADDR, a[7:0]);
		wreg(IDX_DHI, d[15:8]);
		wreg(IDX_DLO, d[7:0]);
		wreg(IDX_CTRL, {a[8], 4'h0, 1'b0, OP_WRITE});
		wreg(IDX_CTRL, {a[8], 4'h0, 1'b1, op});
		k = 0;
		rreg(IDX_STATUS, s);
		while (s[0] !== 1'b1 && k < 2000) begin
			k++;
			rreg(IDX_STATUS, s);
		end
		if (op == OP_WRITE) chk(16'(k >= P / 2 && k <= P), 16'h1);
		rreg(IDX_CTRL, s);
		chk(16'(s[2]), 16'h0);
	endtask
	task automatic hwrite(input logic [8:0] a, input logic [15:0] d);
		hop(a, OP_WRITE, d);
		mem[a] = d;
	endtask
	task automatic hread(input logic [8:0] a);
		logic [7:0] h;
		logic [7:0] l;
		hop(a, OP_READ, ~ex(a));
		rreg(IDX_DHI, h);
		rreg(IDX_DLO, l);
		chk({h, l}, ex(a));
	endtask
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_errors++;
			results();
		end
	end
	initial begin
		{rstn, wr, rd, cfg, idx, wdat} = {4'h1, 16'h0};
		{n_errors, n_checks, cyc, seed} = {32'h0, 32'h0, 32'h0, 32'd235};
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		for (j = 240; j < 244; j++) begin
			rreg(8'(j), v);
			chk(16'(v), 16'h0);
		end
		rreg(IDX_STATUS, v);
		chk(16'(v[0]), 16'h1);
		$display("test reset done");
		wreg(IDX_ADDR, 8'h5a);
		rreg(IDX_ADDR, v);
		chk(16'(v), 16'h5a);
		wreg(IDX_CTRL, 8'h80);
		rreg(IDX_CTRL, v);
		chk(16'(v), 16'h80);
		cfg <= 1'b0;
		wreg(IDX_ADDR, 8'ha5);
		rreg(IDX_ADDR, v);
		chk(16'(v), 16'h0);
		cfg <= 1'b1;
		rreg(IDX_ADDR, v);
		chk(16'(v), 16'h5a);
		rreg(8'h77, v);
		chk(16'(v), 16'h0);
		for (j = 0; j < 4; j += 3) begin
			wreg(IDX_CTRL, {6'h01, 2'(j)});
			rreg(IDX_STATUS, v);
			chk(16'(v[0]), 16'h0);
			rreg(IDX_CTRL, v);
			chk(16'(v[2]), 16'h0);
		end
		$display("test regs done");
		for (j = 0; j < 10; j++) begin
			ad = j < 4 ? 9'(j / 2 * 256 + j % 2 * 127) : 9'($unsigned($random(seed)) % W);
			hwrite(ad, 16'($random(seed)));
			hread(ad);
		end
		hread(9'h1ff);
		$display("test array done");
		rw = 16'($random(seed));
		card.xfer(2'b01, 8'h21, rw, sr);
		chk(16'(sr[0]), 16'h1);
		mem[33] = rw;
		hread(9'h021);
		hwrite(9'h042, 16'h8421);
		card.xfer(2'b10, 8'h42, 16'h0, sr);
		chk(16'(sr), 16'h8421);
		chk(16'(sr[16]), 16'h0);
		fork
			hwrite(9'h1c0, 16'h3c5a);
			card.xfer(2'b01, 8'h30, 16'hc3a5, sr);
		join
		chk(16'(sr[0]), 16'h1);
		mem[48] = 16'hc3a5;
		hread(9'h1c0);
		hread(9'h030);
		$display("test serial done");
		results();
	end
endmodule // isa_config_eeprom_programmer_tb
`default_nettype wire
